// ==== hw/cesp_pkg.sv ====
// Constants for the serial programming controller of a configuration EEPROM.
// Assumes a 10 MHz system clock; the link clock is divided down from it.
package cesp_pkg;

  // System clock and serial clock timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);

  // Link framing
  localparam logic [3:0] ACK_BIT    = 4'h8;
  localparam logic [2:0] IDX_DEV    = 3'h0;
  localparam logic [2:0] IDX_ADDR_HI = 3'h1;
  localparam logic [2:0] IDX_ADDR_MD = 3'h2;
  localparam logic [2:0] IDX_ADDR_LO = 3'h3;
  localparam logic [2:0] IDX_DATA   = 3'h4;
  localparam int         ADDR_BITS  = 17;
  localparam logic [7:0] PAGE_LAST  = 8'h7f;
  localparam logic       DIR_WRITE  = 1'b0;

  // Reset values
  localparam logic RST_SCL   = 1'b1;
  localparam logic RST_SEL_N = 1'b1;

  // Quarter phases of one bit slot
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam logic [1:0] PH_3 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_BYTE  = 3'h2,
    ST_STOP  = 3'h3,
    ST_WAIT  = 3'h4
  } cesp_state_e;

endpackage

// ==== hw/cesp_sync2.sv ====
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a pin level with no timing relation to clock.
`timescale 1ns/1ps
`default_nettype none
module cesp_sync2 (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// ==== hw/cesp_programmer.sv ====
// Programmer for the two-wire serial port of a configuration EEPROM.
// Assumes a pull-up on the data line and a 10 MHz clock.
//
// Summary of operation
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Hold select low through write cycle
// - Receiver acknowledges by pulling data low
// - New driver takes line before rising clock
// - Address bytes shifted MSB first
// - Data bytes shifted LSB first
// - Three address bytes, each acknowledged
// - Unused address bits sent as zero
// - Page write sends exactly 128 bytes
// - Start, device write, address, data, stop
// - Poll with start and device address
// - Or wait full write-cycle time
// - Data changes only while clock low
// - Eight bits then receiver acknowledge
// - Direction bit zero means write
`timescale 1ns/1ps
`default_nettype none
module cesp_programmer
  import cesp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h55,
  parameter int         T_WR_NS   = 10000000,
  parameter int         WR_CYC    = T_WR_NS / CLK_PERIOD_NS,
  parameter int         POLL_MAX  = WR_CYC / (40 * QTR_CYC) + 1
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        prog_enable,
  input  wire logic        page_start,
  input  wire logic [23:0] page_addr,
  input  wire logic        data_valid,
  input  wire logic [7:0]  data_byte,
  output var  logic        data_ready,
  output var  logic        busy,
  output var  logic        page_done,
  output var  logic        nack_error,
  output var  logic        serial_clock_line,
  output var  logic        serial_data_out,
  output var  logic        serial_data_oe,
  input  wire logic        serial_data_in,
  output var  logic        program_mode_select_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] i,
                                  input logic lsb_first);
    logic [2:0] k;
    k = i[2:0];
    if (lsb_first) begin
      tx_bit = b[k];
    end else begin
      tx_bit = b[3'h7 - k];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data line input synchroniser

  logic sda_in_s;

  cesp_sync2 u_sda_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (serial_data_in),
    .sync_out (sda_in_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  cesp_state_e state_r, state_nxt;
  logic [3:0]  qcnt_r, qcnt_nxt;
  logic [1:0]  ph_r, ph_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic [7:0]  dcnt_r, dcnt_nxt;
  logic [7:0]  cur_r, cur_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [31:0] polls_r, polls_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic        wc_pend_r, wc_pend_nxt;
  logic        scl_r, scl_nxt;
  logic        oe_r, oe_nxt;
  logic        out_r;
  logic        rdy_r, rdy_nxt;
  logic        done_r, done_nxt;
  logic        err_r, err_nxt;
  logic        busy_r, busy_nxt;
  logic        sel_n_r, sel_n_nxt;
  logic        tick;
  logic        stall;

  assign stall = (state_r == ST_BYTE) && (idx_r == IDX_DATA) &&
                 (bit_r == 4'h0) && (ph_r == PH_0) && !data_valid;
  assign tick  = (qcnt_r == QTR_LAST) && !stall;

  always_comb begin
    state_nxt   = state_r;
    qcnt_nxt    = (qcnt_r == QTR_LAST || stall) ? 4'h0 : qcnt_r + 4'h1;
    ph_nxt      = ph_r;
    bit_nxt     = bit_r;
    idx_nxt     = idx_r;
    dcnt_nxt    = dcnt_r;
    cur_nxt     = cur_r;
    addr_nxt    = addr_r;
    polls_nxt   = polls_r;
    wait_nxt    = wait_r;
    wc_pend_nxt = wc_pend_r;
    scl_nxt     = scl_r;
    oe_nxt      = oe_r;
    rdy_nxt     = 1'b0;
    done_nxt    = 1'b0;
    err_nxt     = err_r;
    sel_n_nxt   = sel_n_r;
    if (state_r != ST_IDLE && tick) begin
      ph_nxt = ph_r + 2'h1;
    end
    case (state_r)
      ST_IDLE: begin
        ph_nxt   = PH_0;
        qcnt_nxt = 4'h0;
        if (prog_enable) begin
          sel_n_nxt = 1'b0;
          if (page_start && !sel_n_r) begin
            // Mask unused high address bits to zero
            addr_nxt  = page_addr & 24'((1 << ADDR_BITS) - 1);
            polls_nxt = 32'h0;
            dcnt_nxt  = 8'h00;
            err_nxt   = 1'b0;
            state_nxt = ST_START;
          end
        end else if (wc_pend_r) begin
          wait_nxt  = 32'h0;
          state_nxt = ST_WAIT;
        end else begin
          sel_n_nxt = 1'b1;
        end
      end
      ST_START: begin
        if (tick) begin
          case (ph_r)
            PH_0: scl_nxt = 1'b0;
            PH_1: oe_nxt  = 1'b0;
            PH_2: scl_nxt = 1'b1;
            PH_3: begin
              oe_nxt    = 1'b1;
              bit_nxt   = 4'h0;
              idx_nxt   = IDX_DEV;
              state_nxt = ST_BYTE;
            end
            default: scl_nxt = 1'b1;
          endcase
        end
      end
      ST_BYTE: begin
        if (tick) begin
          case (ph_r)
            PH_0: begin
              scl_nxt = 1'b0;
              if (bit_r == 4'h0) begin
                case (idx_r)
                  IDX_DEV:     cur_nxt = {DEV_ADDR, DIR_WRITE};
                  IDX_ADDR_HI: cur_nxt = addr_r[23:16];
                  IDX_ADDR_MD: cur_nxt = addr_r[15:8];
                  IDX_ADDR_LO: cur_nxt = addr_r[7:0];
                  default: begin
                    cur_nxt = data_byte;
                    rdy_nxt = 1'b1;
                  end
                endcase
              end
            end
            PH_1: begin
              // Drive only while clock low
              if (bit_r == ACK_BIT) begin
                oe_nxt = 1'b0;
              end else begin
                oe_nxt = !tx_bit(cur_r, bit_r, idx_r == IDX_DATA);
              end
            end
            PH_2: scl_nxt = 1'b1;
            PH_3: begin
              bit_nxt = bit_r + 4'h1;
              if (bit_r == ACK_BIT) begin
                bit_nxt = 4'h0;
                if (sda_in_s) begin
                  if (idx_r == IDX_DEV && polls_r < 32'(POLL_MAX)) begin
                    // Busy device: retry without a stop
                    polls_nxt = polls_r + 32'h1;
                    state_nxt = ST_START;
                  end else begin
                    err_nxt   = 1'b1;
                    state_nxt = ST_STOP;
                  end
                end else if (idx_r != IDX_DATA) begin
                  idx_nxt = idx_r + 3'h1;
                end else begin
                  dcnt_nxt = dcnt_r + 8'h1;
                  if (dcnt_r == PAGE_LAST) begin
                    state_nxt = ST_STOP;
                  end
                end
              end
            end
            default: scl_nxt = 1'b1;
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          case (ph_r)
            PH_0: scl_nxt = 1'b0;
            PH_1: oe_nxt  = 1'b1;
            PH_2: scl_nxt = 1'b1;
            PH_3: begin
              oe_nxt      = 1'b0;
              wc_pend_nxt = 1'b1;
              done_nxt    = 1'b1;
              state_nxt   = ST_IDLE;
            end
            default: scl_nxt = 1'b1;
          endcase
        end
      end
      ST_WAIT: begin
        // Select stays low and lines still
        qcnt_nxt = 4'h0;
        wait_nxt = wait_r + 32'h1;
        if (wait_r == 32'(WR_CYC - 1)) begin
          wc_pend_nxt = 1'b0;
          state_nxt   = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (state_nxt != ST_IDLE && state_r == ST_IDLE) begin
      ph_nxt = PH_0;
    end
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      qcnt_r    <= 4'h0;
      ph_r      <= PH_0;
      bit_r     <= 4'h0;
      idx_r     <= IDX_DEV;
      dcnt_r    <= 8'h00;
      cur_r     <= 8'h00;
      addr_r    <= 24'h000000;
      polls_r   <= 32'h0;
      wait_r    <= 32'h0;
      wc_pend_r <= 1'b0;
      scl_r     <= RST_SCL;
      oe_r      <= 1'b0;
      out_r     <= 1'b0;
      rdy_r     <= 1'b0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      busy_r    <= 1'b0;
      sel_n_r   <= RST_SEL_N;
    end else begin
      state_r   <= state_nxt;
      qcnt_r    <= qcnt_nxt;
      ph_r      <= ph_nxt;
      bit_r     <= bit_nxt;
      idx_r     <= idx_nxt;
      dcnt_r    <= dcnt_nxt;
      cur_r     <= cur_nxt;
      addr_r    <= addr_nxt;
      polls_r   <= polls_nxt;
      wait_r    <= wait_nxt;
      wc_pend_r <= wc_pend_nxt;
      scl_r     <= scl_nxt;
      oe_r      <= oe_nxt;
      out_r     <= 1'b0;
      rdy_r     <= rdy_nxt;
      done_r    <= done_nxt;
      err_r     <= err_nxt;
      busy_r    <= busy_nxt;
      sel_n_r   <= sel_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign data_ready            = rdy_r;
  assign busy                  = busy_r;
  assign page_done             = done_r;
  assign nack_error            = err_r;
  assign serial_clock_line     = scl_r;
  assign serial_data_out       = out_r;
  assign serial_data_oe        = oe_r;
  assign program_mode_select_n = sel_n_r;

endmodule
`default_nettype wire

// ==== testbench/cesp_programmer_props.sv ====
// Port checker for the serial programmer.
// Assumes it is bound to cesp_programmer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cesp_programmer_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic prog_enable,
  input wire logic page_start,
  input wire logic data_ready,
  input wire logic busy,
  input wire logic page_done,
  input wire logic serial_clock_line,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic program_mode_select_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_clk_hold;
    serial_clock_line [*4];
  endsequence
  sequence s_start;
    $rose(serial_data_oe) && serial_clock_line;
  endsequence
  sequence s_stop;
    $fell(serial_data_oe) && serial_clock_line;
  endsequence
  a_open_drain: assert property (serial_data_out == 1'b0)
    else $error("data line driven high");
  a_clk_high: assert property
    ($rose(serial_clock_line) |-> s_clk_hold)
    else $error("clock high phase too short");
  a_start_clk: assert property
    (s_start |-> ##[1:3] !serial_clock_line)
    else $error("no clock after start");
  a_stop_idle: assert property (s_stop |-> s_clk_hold)
    else $error("clock moved after stop");
  a_ready_pulse: assert property (data_ready |=> !data_ready)
    else $error("ready longer than one cycle");
  a_ready_busy: assert property (data_ready |-> busy)
    else $error("byte taken while idle");
  a_done_pulse: assert property (page_done |=> !page_done)
    else $error("done longer than one cycle");
  a_busy_start: assert property (!busy && !page_done
    && prog_enable && !program_mode_select_n && page_start |=> busy)
    else $error("page request not taken");
  a_sel_held: assert property (busy |-> !program_mode_select_n)
    else $error("select released while busy");
  a_idle_quiet: assert property (!busy && !page_done
    |-> serial_clock_line && !serial_data_oe)
    else $error("link not idle");
endmodule
`default_nettype wire

// ==== testbench/cesp_eeprom_model.sv ====
// Behavioural model of the EEPROM's two-wire programming port.
// Assumes a pull-up on the data line; works on the pin edges.
`timescale 1ns/1ps
`default_nettype none
module cesp_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h55,
  parameter int         T_WR_NS  = 15000
) (
  input  wire logic serial_clock_line,
  input  wire logic serial_data_line,
  input  wire logic program_mode_select_n,
  input  wire logic hold_busy,
  output var  logic data_pull
);
  logic [7:0]  mem [int];
  logic [23:0] addr_r = '0;
  logic [7:0]  shift_r = '0;
  int          bit_cnt = 0, byte_idx = 0, n_data = 0, n_polls = 0, n_slip = 0;
  logic        active = 0, wr_busy = 0, wrote = 0;
  event        wr_go;
  wire         busy_w = wr_busy | hold_busy;
  initial data_pull = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  always @(serial_data_line) begin
    if (serial_clock_line && !program_mode_select_n) begin
      if (busy_w) begin
        if (!serial_data_line) n_polls++;
      end else if (!serial_data_line) begin
        active = 1;
        bit_cnt = 0;
        byte_idx = 0;
        wrote = 0;
        data_pull = 0;
      end else begin
        if (active && wrote) -> wr_go;
        active = 0;
      end
    end
  end
  always @(wr_go) begin
    wr_busy = 1;
    #(T_WR_NS);
    wr_busy = 0;
  end
  always @(posedge program_mode_select_n) if (busy_w) n_slip++;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge serial_clock_line) begin
    if (active && bit_cnt < 8) begin
      shift_r = {shift_r[6:0], serial_data_line};
      bit_cnt++;
    end
  end
  always @(negedge serial_clock_line) begin
    if (active && bit_cnt == 8) begin
      data_pull = 1;
      if (byte_idx == 0) begin
        data_pull = (shift_r == {DEV_ADDR, 1'b0});
      end else if (byte_idx < 4) begin
        addr_r = {addr_r[15:0], shift_r};
      end else begin
        mem[int'(addr_r)] = {<<{shift_r}};
        addr_r[6:0] = addr_r[6:0] + 7'h1;
        n_data++;
        wrote = 1;
      end
      active = data_pull;
      byte_idx++;
      bit_cnt = 9;
    end else if (active && bit_cnt == 9) begin
      data_pull = 0;
      bit_cnt = 0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/config_eeprom_serial_programming_tb.sv ====
// Self-checking bench for the serial programmer against a device model.
// Assumes cesp_pkg, the programmer and the model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module config_eeprom_serial_programming_tb;
  logic        clock = 0, rst_n = 0, prog_enable = 0, page_start = 0;
  logic        data_valid = 0, hold_busy = 0;
  logic [23:0] page_addr = '0;
  logic [7:0]  data_byte = '0;
  logic        data_ready, busy, page_done, nack_error, scl, sda_o, sda_oe;
  logic        sel_n, dev_pull;
  wire         sda = !(sda_oe || dev_pull);
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  always #50 clock = ~clock;
  cesp_programmer #(.T_WR_NS(20000)) dut_u (.clock(clock), .rst_n(rst_n),
    .prog_enable(prog_enable), .page_start(page_start),
    .page_addr(page_addr), .data_valid(data_valid), .data_byte(data_byte),
    .data_ready(data_ready), .busy(busy), .page_done(page_done),
    .nack_error(nack_error), .serial_clock_line(scl),
    .serial_data_out(sda_o), .serial_data_oe(sda_oe),
    .serial_data_in(sda), .program_mode_select_n(sel_n));
  cesp_eeprom_model partner_u (.serial_clock_line(scl),
    .serial_data_line(sda), .program_mode_select_n(sel_n),
    .hold_busy(hold_busy), .data_pull(dev_pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("counts: %0d compared, %0d failed", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_page(input logic [23:0] base, input logic [7:0] key,
                          input int n);
    int t;
    page_addr <= base;
    page_start <= 1'b1;
    @(posedge clock);
    page_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == 64) begin
        // Gap in the byte stream stalls the link
        data_valid <= 1'b0;
        repeat (100) @(posedge clock);
      end
      data_valid <= 1'b1;
      data_byte <= 8'(i) ^ key;
      t = 0;
      do begin
        @(posedge clock);
        t++;
      end while (data_ready !== 1'b1 && t < 3000);
      if (t >= 3000) n_fail++;
    end
    data_valid <= 1'b0;
    t = 0;
    while (page_done !== 1'b1 && t < 3000) begin
      @(posedge clock);
      t++;
    end
    if (t >= 3000) n_fail++;
  endtask
  task automatic check_page(input logic [23:0] base, input logic [7:0] key);
    logic [23:0] a;
    for (int i = 0; i < 128; i++) begin
      a = {7'h0, base[16:7], 7'(base[6:0] + 7'(i))};
      check("stored byte", {24'h0, 8'(i) ^ key},
            {24'h0, partner_u.mem[int'(a)]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_wrap();
    int n0 = partner_u.n_data;
    run_page(24'hf3457e, 8'h5a, 128);
    check_page(24'hf3457e, 8'h5a);
    check("data count", 128, 32'(partner_u.n_data - n0));
    check("error flag", 0, {31'h0, nack_error});
    $display("test wrap done");
  endtask
  task automatic test_poll();
    int p0 = partner_u.n_polls;
    run_page(24'h000000, 8'hc3, 128);
    check_page(24'h000000, 8'hc3);
    check("polled", 1, {31'h0, partner_u.n_polls > p0});
    check("error flag", 0, {31'h0, nack_error});
    $display("test poll done");
  endtask
  task automatic test_refuse();
    int n0 = partner_u.n_data;
    hold_busy <= 1'b1;
    run_page(24'h000100, 8'h00, 0);
    check("error flag", 1, {31'h0, nack_error});
    check("data count", 0, 32'(partner_u.n_data - n0));
    hold_busy <= 1'b0;
    run_page(24'h000280, 8'h77, 128);
    check_page(24'h000280, 8'h77);
    check("error flag", 0, {31'h0, nack_error});
    $display("test refuse done");
  endtask
  task automatic test_exit();
    int t = 0;
    prog_enable <= 1'b0;
    while (sel_n !== 1'b1 && t < 1000) begin
      @(posedge clock);
      t++;
    end
    check("select released", 1, {31'h0, sel_n});
    check("wait long", 1, {31'h0, t >= 200 && t <= 210});
    check("select slips", 0, 32'(partner_u.n_slip));
    $display("test exit done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    prog_enable <= 1'b1;
    repeat (3) @(posedge clock);
    test_wrap();
    test_poll();
    test_refuse();
    test_exit();
    print_verdict();
  end
endmodule
bind cesp_programmer cesp_programmer_props props_u (.clock(clock),
  .rst_n(rst_n), .prog_enable(prog_enable), .page_start(page_start),
  .data_ready(data_ready), .busy(busy), .page_done(page_done),
  .serial_clock_line(serial_clock_line), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe),
  .program_mode_select_n(program_mode_select_n));
`default_nettype wire
